/* File: ut16_timer.sv */
/*
  Sixteen-bit binary up timer with a 7-bit prescaler on a 3-bit code, source select,
  overflow flag with interrupt, and a coherent low/high byte latch.
  Assumes fcpuTick and fhoscTick are one-cycle enables synchronous to core_clk,
  captureDone is a one-cycle pulse from the capture sub-block, and software
  reaches the registers over a plain strobe port with read data one cycle later.
*/
`timescale 1ns/10ps

// Behaviour
// - The counter holds while the run bit is 0 and advances while it is 1.
// - While running the count rises by one per prescaled timer clock cycle.
// - A step from 0xFFFF to 0x0000 is an overflow, and the count wraps to zero.
// - Each overflow sets the overflow flag, which only a software write of 0 clears.
// - No automatic reload happens; counting carries on upward from zero.
// - With the interrupt enable set, a set flag raises the interrupt request.
// - Source select 0 takes the instruction clock, 1 the high-speed oscillator clock.
// - Prescale codes 000 to 111 divide the source by 128 down to 1.
// - A high byte write is held and the low byte write loads all 16 bits at once.
// - A low byte read captures the whole count and the high byte read returns its top half.
// - The timer counts and flags in every power mode, but never wakes from low power.
// - A finished capture measurement sets the same flag and interrupt.
module ut16_timer
  import ut16_pkg::*;
(
  // Clock and reset.
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Register port.
  input  wire logic [7:0]        regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  // Timer clock sources.
  input  wire logic              fcpuTick,
  input  wire logic              fhoscTick,
  // System side.
  input  wire logic              captureDone,
  input  wire logic              lowPowerMode,
  output logic                   irqOut,
  output logic                   wakeReq
);

  // Stored state.
  logic [4:0]        modeReg;
  logic [CNT_W-1:0]  countReg;
  logic [DATA_W-1:0] hiHoldReg;
  logic [CNT_W-1:0]  snapReg;
  logic [PRE_W-1:0]  preReg;
  logic              ovfFlagReg;
  logic              ienReg;
  logic [STS_W-1:0]  stsReg;
  logic [STS_W-1:0]  maskReg;

  // Decoded strobes and derived terms.
  logic              wrMode;
  logic              wrLo;
  logic              wrHi;
  logic              wrCtrl;
  logic              wrMask;
  logic              rdLo;
  logic              rdSts;
  logic              runBit;
  logic              srcTick;
  logic [2:0]        preCode;
  logic [PRE_W-1:0]  divMask;
  logic              stepNow;
  logic              ovfEvent;
  logic              ovfFlagNext;
  logic [STS_W-1:0]  stsNext;
  logic              irqNext;
  logic              ienNext;
  logic [STS_W-1:0]  maskNext;
  logic [DATA_W-1:0] rdNext;

  // Address decode of the strobes.
  assign wrMode = regWr && (regAddr == OFS_MODE);
  assign wrLo   = regWr && (regAddr == OFS_CNT_LO);
  assign wrHi   = regWr && (regAddr == OFS_CNT_HI);
  assign wrCtrl = regWr && (regAddr == OFS_IRQ_CTRL);
  assign wrMask = regWr && (regAddr == OFS_IRQ_MASK);
  assign rdLo   = regRd && (regAddr == OFS_CNT_LO);
  assign rdSts  = regRd && (regAddr == OFS_IRQ_STS);

  // Mode fields.
  assign runBit  = modeReg[MODE_RUN_BIT-MODE_LSB];
  assign preCode = modeReg[MODE_PRE_HI-MODE_LSB:MODE_PRE_LO-MODE_LSB];

  // Source select picks which enable feeds the prescaler.
  assign srcTick = modeReg[MODE_SRC_BIT-MODE_LSB] ? fhoscTick : fcpuTick;

  // Code n divides by 128 >> n: the step fires when the low 7-n bits are all ones.
  assign divMask = PRE_FULL >> preCode;
  assign stepNow = runBit && srcTick && ((preReg & divMask) == divMask);

  // Overflow is the step taken from full scale; the wrap to zero is free.
  assign ovfEvent = stepNow && (countReg == CNT_FULL);

  // Set wins over a software clear in the same cycle.
  always_comb begin
    ovfFlagNext = ovfFlagReg;
    if (wrCtrl && !regWdata[CTRL_FLAG_BIT]) begin
      ovfFlagNext = 1'b0;
    end
    if (ovfEvent || captureDone) begin
      ovfFlagNext = 1'b1;
    end
  end

  // Sticky status, cleared by a read, but a new event in that cycle survives.
  always_comb begin
    stsNext = rdSts ? STS_RST : stsReg;
    stsNext[STS_OVF_BIT] = stsNext[STS_OVF_BIT] | ovfEvent;
    stsNext[STS_CAP_BIT] = stsNext[STS_CAP_BIT] | captureDone;
  end

  // Enable and mask as they stand after this edge, so a write that turns on the
  // enable while the flag is already set raises irqOut at once rather than late.
  assign ienNext  = wrCtrl ? regWdata[CTRL_IEN_BIT] : ienReg;
  assign maskNext = wrMask ? regWdata[STS_W-1:0] : maskReg;

  // Interrupt from the enabled flag or from any unmasked status bit.
  assign irqNext = (ovfFlagNext && ienNext) || ((stsNext & maskNext) != STS_RST);

  // Read data mux; the high byte comes from the snapshot, not the live count.
  always_comb begin
    rdNext = RD_NONE;
    case (regAddr)
      OFS_MODE:     rdNext = {modeReg, 3'h0};
      OFS_CNT_LO:   rdNext = countReg[7:0];
      OFS_CNT_HI:   rdNext = snapReg[15:8];
      OFS_IRQ_CTRL: rdNext = {6'h00, ienReg, ovfFlagReg};
      OFS_IRQ_STS:  rdNext = {6'h00, stsReg};
      OFS_IRQ_MASK: rdNext = {6'h00, maskReg};
      default:      rdNext = RD_NONE;
    endcase
  end

  // Mode register keeps only bits 7..3; the low bits are not stored.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modeReg <= MODE_RST;
    end else if (wrMode) begin
      modeReg <= regWdata[7:MODE_LSB];
    end
  end

  // Prescaler restarts while stopped so the first period after start is whole.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      preReg <= PRE_RST;
    end else if (!runBit) begin
      preReg <= PRE_RST;
    end else if (srcTick) begin
      preReg <= preReg + PRE_ONE;
    end
  end

  // Counter: a low byte write loads all 16 bits and wins over a step.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      countReg <= CNT_RST;
    end else if (wrLo) begin
      countReg <= {hiHoldReg, regWdata};
    end else if (stepNow) begin
      countReg <= countReg + CNT_ONE;
    end
  end

  // High byte write is held until the next high write; every low byte write loads it.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      hiHoldReg <= RD_NONE;
    end else if (wrHi) begin
      hiHoldReg <= regWdata;
    end
  end

  // Snapshot on a low byte read so the later high read is coherent.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      snapReg <= CNT_RST;
    end else if (rdLo) begin
      snapReg <= countReg;
    end
  end

  // Overflow flag and its enable.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ovfFlagReg <= 1'b0;
      ienReg     <= 1'b0;
    end else begin
      ovfFlagReg <= ovfFlagNext;
      if (wrCtrl) begin
        ienReg <= regWdata[CTRL_IEN_BIT];
      end
    end
  end

  // Status and mask registers.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stsReg  <= STS_RST;
      maskReg <= STS_RST;
    end else begin
      stsReg <= stsNext;
      if (wrMask) begin
        maskReg <= regWdata[STS_W-1:0];
      end
    end
  end

  // Outputs; counting never looks at lowPowerMode, only the wake does.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      regRdata <= RD_NONE;
      irqOut   <= 1'b0;
      wakeReq  <= 1'b0;
    end else begin
      regRdata <= regRd ? rdNext : RD_NONE;
      irqOut   <= irqNext;
      wakeReq  <= irqNext && !lowPowerMode;
    end
  end

  // Checks.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rdLo;
    regRd && (regAddr == OFS_CNT_LO);
  endsequence

  sequence s_rdHi;
    regRd && (regAddr == OFS_CNT_HI);
  endsequence

  property p_freeze;
    (!runBit && !wrLo) |=> $stable(countReg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Counter moved while stopped.");

  property p_step;
    (stepNow && !wrLo) |=> (countReg == $past(countReg) + CNT_ONE);
  endproperty
  a_step: assert property (p_step) else $error("Counter did not step by one.");

  property p_wrap;
    (stepNow && !wrLo && countReg == CNT_FULL) |=> (countReg == CNT_RST) && ovfFlagReg;
  endproperty
  a_wrap: assert property (p_wrap) else $error("Overflow did not wrap and flag.");

  property p_sticky;
    (ovfFlagReg && !(wrCtrl && !regWdata[CTRL_FLAG_BIT])) |=> ovfFlagReg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Flag dropped without a clear.");

  property p_irq;
    (ovfFlagReg && ienReg) |-> irqOut;
  endproperty
  a_irq: assert property (p_irq) else $error("Enabled flag gave no interrupt.");

  property p_div1;
    (runBit && srcTick && preCode == 3'h7) |-> stepNow;
  endproperty
  a_div1: assert property (p_div1) else $error("Divide by one missed a tick.");

  property p_wlatch;
    wrLo |=> (countReg == {$past(hiHoldReg), $past(regWdata)});
  endproperty
  a_wlatch: assert property (p_wlatch) else $error("Low write did not load 16 bits.");

  property p_rlatch;
    s_rdLo ##1 s_rdHi |=> (regRdata == $past(countReg[15:8], 2));
  endproperty
  a_rlatch: assert property (p_rlatch) else $error("High read not from snapshot.");

  property p_lowpwr;
    lowPowerMode |=> !wakeReq;
  endproperty
  a_lowpwr: assert property (p_lowpwr) else $error("Wake raised in low power.");

  property p_capt;
    captureDone |=> ovfFlagReg;
  endproperty
  a_capt: assert property (p_capt) else $error("Capture end did not set flag.");

  property p_modelow;
    (regRd && regAddr == OFS_MODE) |=> (regRdata[2:0] == 3'h0);
  endproperty
  a_modelow: assert property (p_modelow) else $error("Mode low bits not zero.");

  // The checks below pin the same behaviour from the other side: holds, clears and routing.
  property p_hihold;
    (wrHi && !stepNow) |=> $stable(countReg);
  endproperty
  a_hihold: assert property (p_hihold) else $error("High write reached the counter.");

  property p_snap;
    s_rdLo |=> (snapReg == $past(countReg));
  endproperty
  a_snap: assert property (p_snap) else $error("Low read missed the snapshot.");

  property p_prestop;
    !runBit |=> (preReg == PRE_RST);
  endproperty
  a_prestop: assert property (p_prestop) else $error("Prescaler ran while stopped.");

  property p_srcsel;
    (runBit && !modeReg[MODE_SRC_BIT-MODE_LSB] && !fcpuTick) |-> !stepNow;
  endproperty
  a_srcsel: assert property (p_srcsel) else $error("Stepped on the wrong source.");

  property p_flagclr;
    (wrCtrl && !regWdata[CTRL_FLAG_BIT] && !ovfEvent && !captureDone) |=> !ovfFlagReg;
  endproperty
  a_flagclr: assert property (p_flagclr) else $error("Flag clear write ignored.");

  property p_ovfsts;
    ovfEvent |=> stsReg[STS_OVF_BIT];
  endproperty
  a_ovfsts: assert property (p_ovfsts) else $error("Overflow missed in status.");

  property p_capsts;
    captureDone |=> stsReg[STS_CAP_BIT];
  endproperty
  a_capsts: assert property (p_capsts) else $error("Capture missed in status.");

  property p_ovfirq;
    (ovfEvent && ienReg && !wrCtrl) |=> irqOut;
  endproperty
  a_ovfirq: assert property (p_ovfirq) else $error("Overflow gave no interrupt.");

  property p_irqoff;
    (!(ovfFlagReg && ienReg) && ((stsReg & maskReg) == STS_RST)) |-> !irqOut;
  endproperty
  a_irqoff: assert property (p_irqoff) else $error("Interrupt with no cause.");

  property p_wake;
    !lowPowerMode |=> (wakeReq == irqOut);
  endproperty
  a_wake: assert property (p_wake) else $error("Wake did not follow interrupt.");

endmodule

/* File: ut16_pkg.sv */
/*
  Constants shared by the 16-bit prescaled up timer: register offsets on the
  8-bit core register port, field positions, reset values and widths.
  Assumes an 8-bit core bus with one-cycle strobes and data read one cycle later.
*/
package ut16_pkg;
  // Data widths.
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;
  localparam int PRE_W  = 7;

  // Register offsets.
  localparam logic [7:0] OFS_IRQ_CTRL = 8'hF7;
  localparam logic [7:0] OFS_IRQ_STS  = 8'hF8;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hF9;
  localparam logic [7:0] OFS_MODE     = 8'hFA;
  localparam logic [7:0] OFS_CNT_LO   = 8'hFB;
  localparam logic [7:0] OFS_CNT_HI   = 8'hFC;

  // Mode register fields.
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_PRE_HI  = 6;
  localparam int MODE_PRE_LO  = 4;
  localparam int MODE_SRC_BIT = 3;
  localparam int MODE_LSB     = 3;

  // Interrupt control register fields.
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_IEN_BIT  = 1;

  // Status and mask fields.
  localparam int STS_W       = 2;
  localparam int STS_OVF_BIT = 0;
  localparam int STS_CAP_BIT = 1;

  // Reset values and terminal counts.
  localparam logic [4:0]        MODE_RST = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_FULL = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  localparam logic [PRE_W-1:0]  PRE_RST  = 7'h00;
  localparam logic [PRE_W-1:0]  PRE_ONE  = 7'h01;
  localparam logic [PRE_W-1:0]  PRE_FULL = 7'h7F;
  localparam logic [STS_W-1:0]  STS_RST  = 2'h0;
  localparam logic [DATA_W-1:0] RD_NONE  = 8'h00;
endpackage

/* File: tb_top.sv */
/*
  Self-checking bench for the 16-bit prescaled up timer: register access,
  byte latch pairing, counting, prescale codes, overflow and interrupts.
  Assumes the design's own assertions watch the cycle relations; this bench
  drives every input itself at the rising edge of a 10 MHz clock.
*/
`timescale 1ns/10ps

module tb_top;
  import ut16_pkg::*;

  logic        core_clk     = 1'b0;
  logic        sys_rst      = 1'b1;
  logic [7:0]  regAddr      = 8'h00;
  logic [7:0]  regWdata     = 8'h00;
  logic        regWr        = 1'b0;
  logic        regRd        = 1'b0;
  logic [7:0]  regRdata;
  logic        fcpuTick     = 1'b0;
  logic        fhoscTick    = 1'b0;
  logic        captureDone  = 1'b0;
  logic        lowPowerMode = 1'b0;
  logic        irqOut;
  logic        wakeReq;
  int          err_total    = 0;
  int          comparisons  = 0;
  int          seed         = 32'h1A4C;
  logic [15:0] cnt;
  logic [2:0]  code;
  logic        src;
  int          n;

  ut16_timer dut (.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .fcpuTick(fcpuTick), .fhoscTick(fhoscTick), .captureDone(captureDone),
    .lowPowerMode(lowPowerMode), .irqOut(irqOut), .wakeReq(wakeReq));

  // A 100 ns period gives the 10 MHz core clock.
  always #50 core_clk = ~core_clk;

  // Prints the verdict once and ends the run.
  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Compares one value with case equality so an unknown never matches.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // One-cycle read strobe; data is only valid in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  // Back-to-back low and high reads; the high byte must come from the snapshot.
  task automatic rd_pair(input logic [15:0] exp);
    @(posedge core_clk);
    regRd   <= 1'b1;
    regAddr <= OFS_CNT_LO;
    @(posedge core_clk);
    regAddr <= OFS_CNT_HI;
    #1 chk(regRdata, exp[7:0]);
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp[15:8]);
  endtask

  // Ticks the selected source every cycle while the other one and the low-power
  // level toggle at random, since neither of them may change the count.
  task automatic ticks(input logic s, input int k);
    repeat (k) begin
      @(posedge core_clk);
      fcpuTick  <= s ? 1'($random(seed)) : 1'b1;
      fhoscTick <= s ? 1'b1 : 1'($random(seed));
      lowPowerMode <= 1'($random(seed));
    end
    @(posedge core_clk);
    fcpuTick  <= 1'b0;
    fhoscTick <= 1'b0;
    lowPowerMode <= 1'b0;
  endtask

  // Count after k selected ticks, code 0 dividing by 128 down to code 7 by 1.
  function automatic logic [15:0] exp_cnt(logic [15:0] st, int k, logic [2:0] c);
    return st + 16'(k / (128 >> c));
  endfunction

  // A hang is cut short well beyond the expected run length.
  initial begin
    #(100 * 60000);
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int a = 8'hF7; a <= 8'hFC; a++) rd(8'(a), 8'h00);
    wr(8'hF0, 8'hFF);
    rd(8'hF0, 8'h00);
    wr(8'hFA, 8'hFF);
    rd(8'hFA, 8'hF8);
    wr(8'hFC, 8'hA5);
    wr(8'hFB, 8'h3C);
    rd(8'hFB, 8'h3C);
    rd(8'hFC, 8'hA5);
    // Snapshot must survive a step between the two reads.
    wr(8'hFC, 8'h00);
    wr(8'hFB, 8'hFF);
    wr(8'hFA, 8'hF0);
    rd(8'hFB, 8'hFF);
    ticks(1'b0, 1);
    rd(8'hFC, 8'h00);
    wr(8'hFA, 8'h70);
    ticks(1'b0, 5);
    rd(8'hFB, 8'h00);
    rd(8'hFC, 8'h01);
    // Overflow from full scale with the interrupt enabled.
    wr(8'hF7, 8'h02);
    wr(8'hFC, 8'hFF);
    wr(8'hFB, 8'hFF);
    wr(8'hFA, 8'hF0);
    ticks(1'b0, 2);
    #1 chk({7'h00, irqOut}, 8'h01);
    wr(8'hFA, 8'h70);
    rd(8'hFB, 8'h01);
    rd(8'hFC, 8'h00);
    wr(8'hF7, 8'h03);
    rd(8'hF7, 8'h03);
    rd(8'hF8, 8'h01);
    rd(8'hF8, 8'h00);
    wr(8'hF7, 8'h02);
    #1 chk({7'h00, irqOut}, 8'h00);
    // Capture completion in low-power mode raises the interrupt but no wake.
    wr(8'hF7, 8'h00);
    wr(8'hF9, 8'h02);
    @(posedge core_clk);
    lowPowerMode <= 1'b1;
    captureDone  <= 1'b1;
    @(posedge core_clk);
    captureDone <= 1'b0;
    #1 chk({6'h00, irqOut, wakeReq}, 8'h02);
    rd(8'hF7, 8'h01);
    @(posedge core_clk);
    lowPowerMode <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, wakeReq}, 8'h01);
    rd(8'hF8, 8'h02);
    // Enabling with the flag still pending raises the request until software clears it.
    wr(8'hF7, 8'h03);
    #1 chk({7'h00, irqOut}, 8'h01);
    wr(8'hF7, 8'h02);
    #1 chk({7'h00, irqOut}, 8'h00);
    wr(8'hF9, 8'h00);
    // Random loads, codes and sources; the stop write clears the prescaler.
    repeat (8) begin
      cnt  = 16'($random(seed));
      code = 3'($random(seed));
      src  = 1'($random(seed));
      n    = 1 + ($random(seed) & 16'h01FF);
      wr(8'hFA, {1'b0, code, src, 3'h0});
      wr(8'hFC, cnt[15:8]);
      wr(8'hFB, cnt[7:0]);
      wr(8'hFA, {1'b1, code, src, 3'h0});
      ticks(src, n);
      wr(8'hFA, {1'b0, code, src, 3'h0});
      cnt = exp_cnt(cnt, n, code);
      rd_pair(cnt);
    end
    tally_and_finish;
  end
endmodule
